// *** core/apcc_pkg.sv ***
// Package: register map, field layout, timing and carrier types
// How it works
// RQ1: Bit 14 of analog word one shows the synchronised low-supply flag.
// RQ2: Bit 13 of analog word one shows the synchronised button level.
// RQ3: Button held over five seconds pulses system reset unless bit 12 set.
// RQ4: Bit 10 set divides the crystal clock by two with a phase toggle.
// RQ5: Software enables the RF VCO, bit 9, before high-speed USB use.
// RQ6: Bit 8 of analog word one drives the converter power enable.
// RQ7: Software sets all four audio power enables, bits 7 to 4, for stereo.
// RQ8: Gain code decodes 0 to 0 dB, 1 to -12 dB, 3 to -6 dB.
// RQ9: Lock check init pulse arms capture; flag stays set while VCO locked.
// RQ10: Software sets USB pad bias, bit 10, in high-speed mode.
// RQ11: Bit 9 of analog word three switches the 480 MHz clock driver.
// RQ12: Software sets USB transceiver enable, bit 8, whenever USB is used.
// RQ13: Software sweeps VCO centre trim bits 3:0 until lock flag is high.
// RQ14: Software keeps both VCO divider fields, bits 7:6 and 5:4, zero.
// RQ15: Bit 13 of analog word three enables the fine-tune modulator.
// RQ16: Software keeps the fractional coefficient within the VCO divider.
// RQ17: Voltage word holds analog 14:10, IO 9:5 and core 4:0 codes.
// RQ18: Codes and shutdown bits apply only on latch strobe bit 3 rising.
// RQ19: Control word bits 2, 1, 0 shut analog, IO, core regulators.
// RQ20: Software keeps control regulator off, bit 4, clear while in use.
// RQ21: Shadow copy of regulator settings updates only at the strobe edge.
// RQ22: Analog word one sits at index 0xFECB and resets to zero.
package apcc_pkg;

  // Register indices; the APB byte address is four times the index
  localparam logic [15:0] ANA_ONE_IDX   = 16'hFECB;
  localparam logic [15:0] REGU_CTRL_IDX = 16'hFECE;
  localparam logic [15:0] REGULATOR_VOLTAGE_IDX = 16'hFED0;
  localparam logic [15:0] ANA_THREE_IDX = 16'hFED3;
  localparam int unsigned APB_AW        = 18;
  localparam logic [17:0] ANA_ONE_ADDR   = {ANA_ONE_IDX, 2'h0};
  localparam logic [17:0] REGU_CTRL_ADDR = {REGU_CTRL_IDX, 2'h0};
  localparam logic [17:0] REGULATOR_VOLTAGE_ADDR = {REGULATOR_VOLTAGE_IDX, 2'h0};
  localparam logic [17:0] ANA_THREE_ADDR = {ANA_THREE_IDX, 2'h0};

  // Reset values and writable bit masks
  localparam logic [15:0] ANA_ONE_RST     = 16'h0000;
  localparam logic [15:0] ANA_THREE_RST   = 16'h0000;
  localparam logic [15:0] REGU_CTRL_RST   = 16'h0000;
  localparam logic [15:0] REGULATOR_VOLTAGE_RST   = 16'h0000;
  localparam logic [15:0] ANA_ONE_WMASK   = 16'h1FFF;
  localparam logic [15:0] ANA_THREE_WMASK = 16'h2FFF;
  localparam logic [15:0] REGU_CTRL_WMASK = 16'h001F;
  localparam logic [15:0] REGULATOR_VOLTAGE_WMASK = 16'h7FFF;

  // Analog word one fields
  localparam int unsigned SUPPLY_LOW_BIT  = 14;
  localparam int unsigned BUTTON_BIT      = 13;
  localparam int unsigned BTN_DIS_BIT     = 12;
  localparam int unsigned PRESCALE_BIT    = 10;
  localparam int unsigned RF_VCO_BIT      = 9;
  localparam int unsigned CONVERTER_BIT   = 8;
  localparam int unsigned LEFT_DRV_BIT    = 7;
  localparam int unsigned RIGHT_DRV_BIT   = 6;
  localparam int unsigned COMMON_BUF_BIT  = 5;
  localparam int unsigned AUDIO_CORE_BIT  = 4;
  localparam int unsigned RIGHT_GAIN_LSB  = 2;
  localparam int unsigned LEFT_GAIN_LSB   = 0;

  // Analog word three fields
  localparam int unsigned MODULATOR_BIT   = 13;
  localparam int unsigned LOCK_FLAG_BIT   = 12;
  localparam int unsigned LOCK_INIT_BIT   = 11;
  localparam int unsigned PAD_BIAS_BIT    = 10;
  localparam int unsigned HS_CLOCK_BIT    = 9;
  localparam int unsigned TRANSCEIVER_BIT = 8;
  localparam int unsigned CLK_DIV_LSB     = 6;
  localparam int unsigned VCO_DIV_LSB     = 4;
  localparam int unsigned TRIM_LSB        = 0;

  // Regulator fields
  localparam int unsigned ANALOG_CODE_LSB = 10;
  localparam int unsigned IO_CODE_LSB     = 5;
  localparam int unsigned CORE_CODE_LSB   = 0;
  localparam int unsigned CTRL_OFF_BIT    = 4;
  localparam int unsigned STROBE_BIT      = 3;
  localparam int unsigned ANALOG_OFF_BIT  = 2;
  localparam int unsigned IO_OFF_BIT      = 1;
  localparam int unsigned CORE_OFF_BIT    = 0;

  // Gain codes and attenuation in dB
  localparam logic [1:0] GAIN_0DB   = 2'h0;
  localparam logic [1:0] GAIN_M12DB = 2'h1;
  localparam logic [1:0] GAIN_BAD   = 2'h2;
  localparam logic [1:0] GAIN_M6DB  = 2'h3;
  localparam logic [3:0] ATTEN_0DB  = 4'h0;
  localparam logic [3:0] ATTEN_12DB = 4'hC;
  localparam logic [3:0] ATTEN_2DB  = 4'h2;
  localparam logic [3:0] ATTEN_6DB  = 4'h6;

  // Pin indices into the conditioned level vector
  localparam int unsigned PIN_BUTTON = 0;
  localparam int unsigned PIN_SUPPLY = 1;
  localparam int unsigned PIN_LOCK   = 2;

  // Long-press timing at the system clock rate
  localparam longint CLOCK_HZ          = 250_000_000;
  localparam longint LONG_PRESS_S      = 5;
  localparam longint LONG_PRESS_CYCLES = CLOCK_HZ * LONG_PRESS_S;

  // Long-press watcher states, Gray along the press path
  typedef enum logic [1:0] {
    PRESS_IDLE  = 2'h0,
    PRESS_COUNT = 2'h1,
    PRESS_FIRED = 2'h3
  } apcc_press_t;

  typedef struct packed {
    logic [17:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apcc_apb_req_t;

  typedef struct packed {
    logic       long_press_reset_disable;
    logic       crystal_prescale;
    logic       prescale_phase;
    logic       rf_vco_enable;
    logic       converter_enable;
    logic       left_driver_power;
    logic       right_driver_power;
    logic       common_buffer_power;
    logic       audio_core_power;
    logic [1:0] right_gain_sel;
    logic [1:0] left_gain_sel;
    logic       fine_tune_modulator_enable;
    logic       rf_lock_check_init;
    logic       usb_pad_bias_enable;
    logic       hs_clock_driver_enable;
    logic       usb_transceiver_enable;
    logic [1:0] vco_clock_div_sel;
    logic [1:0] vco_div_sel;
    logic [3:0] vco_centre_trim;
    logic       control_regulator_off;
  } apcc_analog_t;

  typedef struct packed {
    logic [4:0] analog_supply_code;
    logic [4:0] io_supply_code;
    logic [4:0] core_supply_code;
    logic       analog_regulator_off;
    logic       io_regulator_off;
    logic       core_regulator_off;
  } apcc_regu_t;

endpackage

// *** core/apcc_pin_watch.sv ***
// Pin synchronisers and power-button long-press reset watcher
`timescale 1ns/1ns
module apcc_pin_watch #(
  parameter int unsigned PINS         = 3,
  parameter logic [30:0] PRESS_CYCLES = 31'(apcc_pkg::LONG_PRESS_CYCLES)
) (
  // Clock and reset
  input  wire logic            i_clock,
  input  wire logic            i_resetn,
  // Raw pins and control
  input  wire logic [PINS-1:0] i_pins,
  input  wire logic            i_press_disable,
  // Conditioned levels and reset request
  output logic      [PINS-1:0] o_levels,
  output logic                 o_long_press
);

  logic [PINS-1:0]     sync_a;
  logic [PINS-1:0]     sync_b;
  logic [PINS-1:0]     sync_c;
  logic [30:0]         count;
  apcc_pkg::apcc_press_t state;
  logic                button;

  // Three stages per pin; a level counts once stages two and three agree
  for (genvar g = 0; g < PINS; g++) begin : g_sync
    always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
        sync_a[g]   <= 1'b0;
        sync_b[g]   <= 1'b0;
        sync_c[g]   <= 1'b0;
        o_levels[g] <= 1'b0;
      end else begin
        sync_a[g] <= i_pins[g];
        sync_b[g] <= sync_a[g];
        sync_c[g] <= sync_b[g];
        if (sync_b[g] == sync_c[g]) begin
          o_levels[g] <= sync_c[g];
        end
      end
    end
  end

  assign button = o_levels[apcc_pkg::PIN_BUTTON];

  // Press timer; releasing the button always restarts it
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state <= apcc_pkg::PRESS_IDLE;
      count <= 31'h00000000;
    end else begin
      case (state)
        apcc_pkg::PRESS_IDLE: begin
          count <= 31'h00000000;
          if (button) state <= apcc_pkg::PRESS_COUNT;
        end
        apcc_pkg::PRESS_COUNT: begin
          if (!button) state <= apcc_pkg::PRESS_IDLE;
          else if (count == PRESS_CYCLES) state <= apcc_pkg::PRESS_FIRED;
          else count <= count + 31'h00000001;
        end
        apcc_pkg::PRESS_FIRED: begin
          if (!button) state <= apcc_pkg::PRESS_IDLE;
        end
        default: state <= apcc_pkg::PRESS_IDLE;
      endcase
    end
  end

  // One pulse per press, strictly past the window; disable suppresses it
  always_ff @(posedge i_clock) begin
    if (!i_resetn) o_long_press <= 1'b0;
    else o_long_press <= (state == apcc_pkg::PRESS_COUNT) && button &&
                         (count == PRESS_CYCLES) && !i_press_disable; // RQ3
  end

endmodule // apcc_pin_watch

// *** core/apcc_ctrl.sv ***
// Analog, power-button and regulator control registers on APB
`timescale 1ns/1ns
module apcc_ctrl #(
  // Long-press window in clock cycles; shorten for simulation
  parameter logic [30:0] PRESS_CYCLES = 31'(apcc_pkg::LONG_PRESS_CYCLES)
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_resetn,
  // APB slave
  input  wire apcc_pkg::apcc_apb_req_t i_apb,
  output logic                  [31:0] o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // Analog status pins
  input  wire logic                    i_button_pin,
  input  wire logic                    i_supply_low,
  input  wire logic                    i_rf_vco_locked,
  // Analog and regulator controls
  output apcc_pkg::apcc_analog_t       o_analog,
  output apcc_pkg::apcc_regu_t         o_regu,
  // Decoded gain
  output logic                   [3:0] o_left_atten_db,
  output logic                   [3:0] o_right_atten_db,
  output logic                         o_gain_distort,
  // System reset request
  output logic                         o_system_reset
);

  logic        setup;
  logic        access;
  logic        wr;
  logic        rd_a1;
  logic        hit_a1;
  logic        hit_a3;
  logic        hit_rc;
  logic        hit_rv;
  logic        hit;
  logic [15:0] ana1;
  logic [15:0] ana3;
  logic [15:0] regu_ctrl;
  logic [15:0] regulator_voltage;
  logic [15:0] next_ana1;
  logic [15:0] next_ana3;
  logic [15:0] next_ctrl;
  logic [15:0] next_volt;
  logic [15:0] rd_mux;
  logic [2:0]  pin_level;
  logic        init_q;
  logic        rf_lock_flag;
  logic        strobe_q;
  logic        latch;
  logic        phase;
  apcc_pkg::apcc_regu_t shadow;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] mask;
    mask  = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~mask) | (data[15:0] & mask);
  endfunction

  // Gain code to attenuation in dB
  function automatic logic [3:0] atten(input logic [1:0] code);
    logic [3:0] db;
    db = apcc_pkg::ATTEN_0DB;
    case (code)
      apcc_pkg::GAIN_0DB:   db = apcc_pkg::ATTEN_0DB;
      apcc_pkg::GAIN_M12DB: db = apcc_pkg::ATTEN_12DB;
      apcc_pkg::GAIN_BAD:   db = apcc_pkg::ATTEN_2DB;
      apcc_pkg::GAIN_M6DB:  db = apcc_pkg::ATTEN_6DB;
      default:              db = apcc_pkg::ATTEN_0DB;
    endcase
    return db;
  endfunction

  // Pin conditioning and long-press reset
  apcc_pin_watch #(
    .PINS         (3),
    .PRESS_CYCLES (PRESS_CYCLES)
  ) u_pin_watch (
    .i_clock         (i_clock),
    .i_resetn        (i_resetn),
    .i_pins          ({i_rf_vco_locked, i_supply_low, i_button_pin}),
    .i_press_disable (ana1[apcc_pkg::BTN_DIS_BIT]),
    .o_levels        (pin_level),
    .o_long_press    (o_system_reset)
  );

  // APB phases; every access completes in its first access cycle
  assign setup    = i_apb.psel & ~i_apb.penable;
  assign access   = i_apb.psel & i_apb.penable;
  assign wr       = access & i_apb.pwrite;
  assign o_pready = access;

  // Address decode
  assign hit_a1 = i_apb.paddr == apcc_pkg::ANA_ONE_ADDR;
  assign hit_a3 = i_apb.paddr == apcc_pkg::ANA_THREE_ADDR;
  assign hit_rc = i_apb.paddr == apcc_pkg::REGU_CTRL_ADDR;
  assign hit_rv = i_apb.paddr == apcc_pkg::REGULATOR_VOLTAGE_ADDR;
  assign hit    = hit_a1 | hit_a3 | hit_rc | hit_rv;
  assign rd_a1  = setup & ~i_apb.pwrite & hit_a1;

  // Candidate write values, reserved and status bits masked off
  assign next_ana1 = merge(ana1, i_apb.pwdata, i_apb.pstrb,
                           apcc_pkg::ANA_ONE_WMASK);
  assign next_ana3 = merge(ana3, i_apb.pwdata, i_apb.pstrb,
                           apcc_pkg::ANA_THREE_WMASK);
  assign next_ctrl = merge(regu_ctrl, i_apb.pwdata, i_apb.pstrb,
                           apcc_pkg::REGU_CTRL_WMASK);
  assign next_volt = merge(regulator_voltage, i_apb.pwdata, i_apb.pstrb,
                           apcc_pkg::REGULATOR_VOLTAGE_WMASK);

  // Analog word one
  always_ff @(posedge i_clock) begin
    if (!i_resetn) ana1 <= apcc_pkg::ANA_ONE_RST; // RQ22
    else if (wr && hit_a1) ana1 <= next_ana1;
  end

  // Analog word three
  always_ff @(posedge i_clock) begin
    if (!i_resetn) ana3 <= apcc_pkg::ANA_THREE_RST;
    else if (wr && hit_a3) ana3 <= next_ana3;
  end

  // Regulator control and voltage words, as software last wrote them
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      regu_ctrl <= apcc_pkg::REGU_CTRL_RST;
      regulator_voltage <= apcc_pkg::REGULATOR_VOLTAGE_RST;
    end else if (wr) begin
      if (hit_rc) regu_ctrl <= next_ctrl;
      if (hit_rv) regulator_voltage <= next_volt;
    end
  end

  // Read data for the addressed word
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_a1) begin
      rd_mux = ana1;
      rd_mux[apcc_pkg::SUPPLY_LOW_BIT] = pin_level[apcc_pkg::PIN_SUPPLY];
      rd_mux[apcc_pkg::BUTTON_BIT]     = pin_level[apcc_pkg::PIN_BUTTON];
    end else if (hit_a3) begin
      rd_mux = ana3;
      rd_mux[apcc_pkg::LOCK_FLAG_BIT] = rf_lock_flag; // RQ9
    end else if (hit_rc) begin
      rd_mux = regu_ctrl;
    end else if (hit_rv) begin
      rd_mux = regulator_voltage;
    end
  end

  // Read data and error are taken in the setup cycle so they come from
  // flip-flops without costing a wait state
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= {16'h0000, rd_mux}; // RQ1 RQ2
      o_pslverr <= ~hit;
    end
  end

  // Lock check: init high arms, its fall captures the lock level, and
  // the flag drops as soon as lock is lost
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      init_q       <= 1'b0;
      rf_lock_flag <= 1'b0;
    end else begin
      init_q <= ana3[apcc_pkg::LOCK_INIT_BIT];
      if (ana3[apcc_pkg::LOCK_INIT_BIT]) rf_lock_flag <= 1'b0;
      else if (init_q) rf_lock_flag <= pin_level[apcc_pkg::PIN_LOCK]; // RQ9
      else rf_lock_flag <= rf_lock_flag & pin_level[apcc_pkg::PIN_LOCK];
    end
  end

  // Divide-by-two phase; clock gating is left to the clock cell
  always_ff @(posedge i_clock) begin
    if (!i_resetn || !ana1[apcc_pkg::PRESCALE_BIT]) phase <= 1'b0;
    else phase <= ~phase; // RQ4
  end

  // Gain decode, registered so the analog side sees clean levels
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_left_atten_db  <= apcc_pkg::ATTEN_0DB;
      o_right_atten_db <= apcc_pkg::ATTEN_0DB;
      o_gain_distort   <= 1'b0;
    end else begin
      o_left_atten_db  <= atten(ana1[apcc_pkg::LEFT_GAIN_LSB +: 2]); // RQ8
      o_right_atten_db <= atten(ana1[apcc_pkg::RIGHT_GAIN_LSB +: 2]);
      o_gain_distort   <=
        (ana1[apcc_pkg::LEFT_GAIN_LSB +: 2] == apcc_pkg::GAIN_BAD) ||
        (ana1[apcc_pkg::RIGHT_GAIN_LSB +: 2] == apcc_pkg::GAIN_BAD);
    end
  end

  // Strobe edge detector
  assign latch = regu_ctrl[apcc_pkg::STROBE_BIT] & ~strobe_q;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) strobe_q <= 1'b0;
    else strobe_q <= regu_ctrl[apcc_pkg::STROBE_BIT];
  end

  // Shadow regulator settings; writes between strobes stay invisible
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      shadow <= '0;
    end else if (latch) begin // RQ18 RQ21
      shadow.analog_supply_code <=
        regulator_voltage[apcc_pkg::ANALOG_CODE_LSB +: 5]; // RQ17
      shadow.io_supply_code   <= regulator_voltage[apcc_pkg::IO_CODE_LSB +: 5];
      shadow.core_supply_code <= regulator_voltage[apcc_pkg::CORE_CODE_LSB +: 5];
      shadow.analog_regulator_off <=
        regu_ctrl[apcc_pkg::ANALOG_OFF_BIT]; // RQ19
      shadow.io_regulator_off   <= regu_ctrl[apcc_pkg::IO_OFF_BIT];
      shadow.core_regulator_off <= regu_ctrl[apcc_pkg::CORE_OFF_BIT];
    end
  end

  assign o_regu = shadow;

  // Analog control fields straight from the register flops
  always_comb begin
    o_analog = '0;
    o_analog.long_press_reset_disable = ana1[apcc_pkg::BTN_DIS_BIT];
    o_analog.crystal_prescale   = ana1[apcc_pkg::PRESCALE_BIT];
    o_analog.prescale_phase     = phase;
    o_analog.rf_vco_enable      = ana1[apcc_pkg::RF_VCO_BIT];
    o_analog.converter_enable   = ana1[apcc_pkg::CONVERTER_BIT]; // RQ6
    o_analog.left_driver_power  = ana1[apcc_pkg::LEFT_DRV_BIT];
    o_analog.right_driver_power = ana1[apcc_pkg::RIGHT_DRV_BIT];
    o_analog.common_buffer_power = ana1[apcc_pkg::COMMON_BUF_BIT];
    o_analog.audio_core_power   = ana1[apcc_pkg::AUDIO_CORE_BIT];
    o_analog.right_gain_sel     = ana1[apcc_pkg::RIGHT_GAIN_LSB +: 2];
    o_analog.left_gain_sel      = ana1[apcc_pkg::LEFT_GAIN_LSB +: 2];
    o_analog.fine_tune_modulator_enable =
      ana3[apcc_pkg::MODULATOR_BIT]; // RQ15
    o_analog.rf_lock_check_init = ana3[apcc_pkg::LOCK_INIT_BIT];
    o_analog.usb_pad_bias_enable = ana3[apcc_pkg::PAD_BIAS_BIT];
    o_analog.hs_clock_driver_enable = ana3[apcc_pkg::HS_CLOCK_BIT]; // RQ11
    o_analog.usb_transceiver_enable = ana3[apcc_pkg::TRANSCEIVER_BIT];
    o_analog.vco_clock_div_sel  = ana3[apcc_pkg::CLK_DIV_LSB +: 2];
    o_analog.vco_div_sel        = ana3[apcc_pkg::VCO_DIV_LSB +: 2];
    o_analog.vco_centre_trim    = ana3[apcc_pkg::TRIM_LSB +: 4];
    o_analog.control_regulator_off = regu_ctrl[apcc_pkg::CTRL_OFF_BIT];
  end

  // Checks on the register behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  sequence s_init_pulse;
    ana3[apcc_pkg::LOCK_INIT_BIT] ##1 !ana3[apcc_pkg::LOCK_INIT_BIT];
  endsequence

  sequence s_write_a1_hi;
    wr && hit_a1 && i_apb.pstrb[1];
  endsequence

  sequence s_write_a3_hi;
    wr && hit_a3 && i_apb.pstrb[1];
  endsequence

  property p_supply_read;
    rd_a1 |=> o_prdata[14] == $past(pin_level[1]);
  endproperty
  a_supply_read: assert property (p_supply_read) // RQ1
    else $error("low-supply bit does not follow the comparator");

  property p_button_read;
    rd_a1 |=> o_prdata[13] == $past(pin_level[0]);
  endproperty
  a_button_read: assert property (p_button_read) // RQ2
    else $error("button bit does not follow the pin");

  property p_reset_cause;
    o_system_reset |-> !$past(ana1[12]) && $past(pin_level[0]);
  endproperty
  a_reset_cause: assert property (p_reset_cause) // RQ3
    else $error("system reset without an enabled long press");

  property p_prescale;
    $past(ana1[10]) ? (phase != $past(phase)) : !phase;
  endproperty
  a_prescale: assert property (p_prescale) // RQ4
    else $error("prescale phase does not divide by two");

  property p_converter;
    s_write_a1_hi |=> o_analog.converter_enable == $past(i_apb.pwdata[8]);
  endproperty
  a_converter: assert property (p_converter) // RQ6
    else $error("converter enable does not follow the write");

  property p_gain;
    wr && hit_a1 && i_apb.pstrb[0] && i_apb.pwdata[1:0] == 2'h3
      |=> ##1 o_left_atten_db == 4'h6;
  endproperty
  a_gain: assert property (p_gain) // RQ8
    else $error("gain code 3 does not decode to 6 dB");

  property p_lock_capture;
    s_init_pulse |=> rf_lock_flag == $past(pin_level[2]);
  endproperty
  a_lock_capture: assert property (p_lock_capture) // RQ9
    else $error("lock flag not captured after the init pulse");

  property p_lock_drop;
    rf_lock_flag && !pin_level[2] && !ana3[11] |=> !rf_lock_flag;
  endproperty
  a_lock_drop: assert property (p_lock_drop) // RQ9
    else $error("lock flag held after lock was lost");

  property p_hs_clock;
    s_write_a3_hi |=> o_analog.hs_clock_driver_enable ==
      $past(i_apb.pwdata[9]) &&
      o_analog.fine_tune_modulator_enable == $past(i_apb.pwdata[13]);
  endproperty
  a_hs_clock: assert property (p_hs_clock) // RQ11 RQ15
    else $error("clock driver or modulator enable missed a write");

  property p_regu_hold;
    !latch |=> $stable(o_regu);
  endproperty
  a_regu_hold: assert property (p_regu_hold) // RQ18 RQ21
    else $error("regulator settings changed without a strobe edge");

  property p_regu_load;
    latch |=> o_regu.analog_supply_code == $past(regulator_voltage[14:10]) &&
      o_regu.core_supply_code == $past(regulator_voltage[4:0]) &&
      o_regu.analog_regulator_off == $past(regu_ctrl[2]) &&
      o_regu.core_regulator_off == $past(regu_ctrl[0]);
  endproperty
  a_regu_load: assert property (p_regu_load) // RQ17 RQ19
    else $error("regulator settings not taken at the strobe edge");

  property p_reset_zero;
    $rose(i_resetn) |-> ana1 == 16'h0000;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // RQ22
    else $error("analog word one not zero after reset");

endmodule // apcc_ctrl

// *** verif/tb_top.sv ***
// Self-checking bench for the analog and regulator control registers
`timescale 1ns/1ns
module tb_top;
  // Design stimulus and observation
  logic                    i_clock         = 1'b0;
  logic                    i_resetn        = 1'b0;
  apcc_pkg::apcc_apb_req_t i_apb           = '0;
  logic                    i_button_pin    = 1'b0;
  logic                    i_supply_low    = 1'b0;
  logic                    i_rf_vco_locked = 1'b0;
  logic             [31:0] o_prdata;
  logic                    o_pready;
  logic                    o_pslverr;
  apcc_pkg::apcc_analog_t  o_analog;
  apcc_pkg::apcc_regu_t    o_regu;
  logic              [3:0] o_left_atten_db;
  logic              [3:0] o_right_atten_db;
  logic                    o_gain_distort;
  logic                    o_system_reset;
  logic             [31:0] rd;
  logic                    seen;
  logic              [3:0] att [4] = '{4'h0, 4'hC, 4'h2, 4'h6};
  int                      err_total   = 0;
  int                      check_count = 0;

  // 250 MHz clock
  always #2 i_clock = ~i_clock;

  // Short long-press window keeps the run brief
  apcc_ctrl #(.PRESS_CYCLES(31'd20)) apcc_ctrl_inst (
    .i_clock, .i_resetn, .i_apb, .o_prdata, .o_pready, .o_pslverr,
    .i_button_pin, .i_supply_low, .i_rf_vco_locked, .o_analog, .o_regu,
    .o_left_atten_db, .o_right_atten_db, .o_gain_distort, .o_system_reset
  );

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_apb <= '{a, 1'b1, 1'b0, w, d, 4'hF};
    @(posedge i_clock);
    i_apb.penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    seen = o_pslverr;
    i_apb.psel <= 1'b0;
    i_apb.penable <= 1'b0;
  endtask

  // Lets pin synchronisers and registered decodes settle
  task settle;
    repeat (6) @(posedge i_clock);
  endtask

  task print_verdict;
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog cuts a hung handshake short
  initial begin
    repeat (5000) @(posedge i_clock);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    apb(0, apcc_pkg::ANA_ONE_ADDR, 0);
    chk("word one reset", 32'h0, rd);
    apb(0, apcc_pkg::REGU_CTRL_ADDR, 0);
    chk("control reset", 32'h0, rd);
    apb(0, apcc_pkg::REGULATOR_VOLTAGE_ADDR, 0);
    chk("voltage reset", 32'h0, rd);
    apb(0, 18'h00000, 0);
    chk("unmapped error", 32'h1, 32'(seen));
    i_supply_low <= 1'b1;
    settle();
    apb(0, apcc_pkg::ANA_ONE_ADDR, 0);
    chk("supply low flag", 32'h4000, rd);
    i_supply_low <= 1'b0;
    // Every gain code on both channels, converter toggling alongside
    for (int g = 0; g < 4; g++) begin
      apb(1, apcc_pkg::ANA_ONE_ADDR, 32'(g * 5 + (g % 2) * 256));
      settle();
      chk("left atten", 32'(att[g]), 32'(o_left_atten_db));
      chk("right atten", 32'(att[g]), 32'(o_right_atten_db));
      chk("distort", 32'(g == 2), 32'(o_gain_distort));
      chk("converter", 32'(g % 2), 32'(o_analog.converter_enable));
      chk("gain sel", 32'(g * 5), 32'({o_analog.right_gain_sel,
        o_analog.left_gain_sel}));
    end
    apb(1, apcc_pkg::ANA_ONE_ADDR, 32'h06F0);
    settle();
    chk("prescale on", 32'h1, 32'(o_analog.crystal_prescale));
    chk("rf vco", 32'h1, 32'(o_analog.rf_vco_enable));
    chk("audio power", 32'hF, 32'({o_analog.left_driver_power,
      o_analog.right_driver_power, o_analog.common_buffer_power,
      o_analog.audio_core_power}));
    seen = o_analog.prescale_phase;
    @(posedge i_clock);
    // Xor keeps an unknown phase from passing as a toggle
    chk("prescale phase", 32'h1, 32'(seen ^ o_analog.prescale_phase));
    // Shadow must ignore writes until the strobe rises
    apb(1, apcc_pkg::REGULATOR_VOLTAGE_ADDR, 32'h5A5A);
    apb(1, apcc_pkg::REGU_CTRL_ADDR, 32'h5);
    settle();
    chk("shadow before", 32'h0, 32'(o_regu));
    chk("ctrl reg", 32'h0, 32'(o_analog.control_regulator_off));
    apb(1, apcc_pkg::REGU_CTRL_ADDR, 32'hD);
    settle();
    chk("shadow latched", {14'h0, 15'h5A5A, 3'h5},
        32'(o_regu));
    apb(1, apcc_pkg::REGULATOR_VOLTAGE_ADDR, 32'h0);
    apb(1, apcc_pkg::REGU_CTRL_ADDR, 32'h8);
    settle();
    chk("shadow held", {14'h0, 15'h5A5A, 3'h5}, 32'(o_regu));
    // Strobe low then high again latches the cleared words
    apb(1, apcc_pkg::REGU_CTRL_ADDR, 32'h0);
    apb(1, apcc_pkg::REGU_CTRL_ADDR, 32'h8);
    settle();
    chk("shadow relatched", 32'h0, 32'(o_regu));
    // Word three enables on then off
    for (int k = 0; k < 2; k++) begin
      apb(1, apcc_pkg::ANA_THREE_ADDR, k ? 32'h0 : 32'h2700);
      settle();
      chk("hs clock", 32'(!k), 32'(o_analog.hs_clock_driver_enable));
      chk("modulator", 32'(!k),
          32'(o_analog.fine_tune_modulator_enable));
      chk("pad bias", 32'(!k), 32'(o_analog.usb_pad_bias_enable));
      chk("usb logic", 32'(!k), 32'(o_analog.usb_transceiver_enable));
    end
    // Lock check: set then clear init, flag follows lock
    i_rf_vco_locked <= 1'b1;
    apb(1, apcc_pkg::ANA_THREE_ADDR, 32'h0805);
    settle();
    chk("lock init", 32'h1, 32'(o_analog.rf_lock_check_init));
    apb(1, apcc_pkg::ANA_THREE_ADDR, 32'h0005);
    settle();
    chk("trim", 32'h5, 32'(o_analog.vco_centre_trim));
    chk("dividers", 32'h0, 32'({o_analog.vco_clock_div_sel,
      o_analog.vco_div_sel}));
    apb(0, apcc_pkg::ANA_THREE_ADDR, 0);
    chk("lock flag", 32'h1005, rd);
    i_rf_vco_locked <= 1'b0;
    settle();
    apb(0, apcc_pkg::ANA_THREE_ADDR, 0);
    chk("lock lost", 32'h0005, rd);
    // Long press with reset enabled, then disabled
    for (int k = 0; k < 2; k++) begin
      apb(1, apcc_pkg::ANA_ONE_ADDR, 32'(k << 12));
      i_button_pin <= 1'b1;
      seen = 1'b0;
      repeat (60) begin
        @(posedge i_clock);
        seen = seen | o_system_reset;
      end
      chk("long press reset", 32'(!k), 32'(seen));
      chk("btn dis", 32'(k), 32'(o_analog.long_press_reset_disable));
      apb(0, apcc_pkg::ANA_ONE_ADDR, 0);
      chk("button level", 32'(k << 12) | 32'h2000, rd);
      i_button_pin <= 1'b0;
      settle();
    end
    print_verdict();
  end
endmodule // tb_top
